// >>> verilog/sers_pkg.sv
// ==========================================================
// Shared constants of the read sequencer
package sers_pkg;
  // ==========================================================
  // Link constants
  localparam int unsigned ADDR_W     = 16;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [6:0]  SLA_ARRAY  = 7'h57;   // 1010111
  localparam logic [6:0]  SLA_CCR    = 7'h6F;   // 1101111
  localparam logic [3:0]  BIT_ACK    = 4'h8;    // Ninth bit slot index
  localparam logic [3:0]  BIT_ZERO   = 4'h0;
  localparam logic [3:0]  BIT_ONE    = 4'h1;
  localparam logic [2:0]  BYTE_MSB   = 3'h7;
  localparam logic [7:0]  LEN_ZERO   = 8'h00;
  localparam logic [7:0]  LEN_ONE    = 8'h01;
  localparam logic [15:0] ADDR_ONE   = 16'h0001;
  // ==========================================================
  // Host commands
  localparam logic [1:0] OP_CUR  = 2'h0;        // Current address read
  localparam logic [1:0] OP_RAND = 2'h1;        // Random read
  localparam logic [1:0] OP_SET  = 2'h2;        // Set current address
  // ==========================================================
  // Host bit timing
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned SCL_QTR_NS    = 625;  // Quarter of a 400 kHz bit
  localparam int unsigned QTR_CYC_I =
    (SCL_QTR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC_I - 1);
  localparam logic [7:0] DIV_ZERO = 8'h00;
  localparam logic [7:0] DIV_ONE  = 8'h01;
  localparam logic [1:0] PH_ONE   = 2'h1;
endpackage

// >>> verilog/sers_bus_if.sv
`timescale 1ns/1ps
// ==========================================================
// Two-wire link between master and memory device
interface sers_bus_if;
  logic scl;      // Clock driven by the master
  logic m_sda_o;  // Master data out
  logic m_sda_oe; // Master data enable
  logic s_sda_o;  // Device data out
  logic s_sda_oe; // Device data enable
  logic sda;      // Resolved wired-and data level

  // Open-drain resolution with pull-up
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport device (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

// >>> verilog/sers_sync.sv
`timescale 1ns/1ps
// ==========================================================
// Two flip-flop level synchroniser
module sers_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,    // Destination clock
  input  wire logic         rst_n,  // Async reset, active low
  input  wire logic [W-1:0] d,      // Asynchronous input
  output logic      [W-1:0] q       // Synchronised output
);
  logic [W-1:0] meta_q;

  // Two stages; only the second stage reads the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// >>> verilog/sers_device.sv
`timescale 1ns/1ps
module sers_device
  import sers_pkg::*;
(
  input  wire logic              link_clk,   // Sampling clock of the link
  input  wire logic              resetn,     // Async reset, active low
  sers_bus_if.device             bus,        // Two-wire link
  output logic [ADDR_W-1:0]      rd_addr_q,  // Read address counter
  output logic                   rd_space_q, // 1 = control register space
  output logic                   rd_take_q,  // Pulse: byte fetched
  input  wire logic [7:0]        rd_data     // Data at rd_addr_q
);
  typedef enum logic [2:0] {
    D_IDLE, D_SLA, D_SLA_ACK, D_WADR, D_WADR_ACK, D_TX, D_TX_ACK, D_WAIT
  } sers_dstate_e;

  sers_dstate_e st_q;
  logic [1:0]   pin_s;
  logic         scl_s;
  logic         sda_s;
  logic         scl_p_q;
  logic         sda_p_q;
  logic         rise;
  logic         fall;
  logic         start;
  logic         stop;
  logic [3:0]   cnt_q;
  logic [7:0]   shift_q;
  logic [7:0]   hi_q;
  logic         wb_q;
  logic         dir_q;
  logic         match;
  logic         fetch;
  logic         load_addr;
  logic         sda_oe_q;
  logic         sda_o_q;

  // ==========================================================
  // Pin synchronisation and condition detect
  sers_sync #(.W(2)) u_sync (
    .clk   (link_clk),
    .rst_n (resetn),
    .d     ({bus.scl, bus.sda}),
    .q     (pin_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // Previous sampled levels
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Edges and bus conditions
  assign rise  = scl_s & ~scl_p_q;
  assign fall  = ~scl_s & scl_p_q;
  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Address pattern compare
  assign match = (shift_q[7:1] == SLA_ARRAY) || (shift_q[7:1] == SLA_CCR);

  // Byte fetch points: after address ack of a read, after master ack
  assign fetch = fall & (((st_q == D_SLA_ACK) & dir_q) | (st_q == D_TX_ACK));
  assign load_addr = fall & (st_q == D_WADR_ACK) & wb_q;

  // ==========================================================
  // Sequencer
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      st_q       <= D_IDLE;
      cnt_q      <= BIT_ZERO;
      shift_q    <= 8'h00;
      hi_q       <= 8'h00;
      wb_q       <= 1'b0;
      dir_q      <= 1'b0;
      rd_space_q <= 1'b0;
    end else if (start) begin
      st_q  <= D_SLA;
      cnt_q <= BIT_ZERO;
    end else if (stop) begin
      st_q <= D_IDLE;  // Standby until the next start
    end else begin
      unique case (st_q)
        D_IDLE, D_WAIT: begin
          st_q <= st_q;  // Bus activity ignored here
        end
        D_SLA, D_WADR: begin
          if (rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q   <= cnt_q + BIT_ONE;
          end else if (fall && cnt_q == BIT_ACK) begin
            if (st_q == D_WADR) begin
              st_q <= D_WADR_ACK;
            end else if (match) begin
              st_q       <= D_SLA_ACK;
              dir_q      <= shift_q[0];
              rd_space_q <= (shift_q[7:1] == SLA_CCR);
            end else begin
              st_q <= D_WAIT;
            end
          end
        end
        D_SLA_ACK: begin
          if (fall) begin
            cnt_q <= BIT_ZERO;
            if (dir_q) begin
              st_q    <= D_TX;
              shift_q <= rd_data;
            end else begin
              st_q <= D_WADR;      // Dummy write
              wb_q <= 1'b0;
            end
          end
        end
        D_WADR_ACK: begin
          if (fall) begin
            cnt_q <= BIT_ZERO;
            if (!wb_q) begin
              hi_q <= shift_q;     // High byte first
              wb_q <= 1'b1;
              st_q <= D_WADR;
            end else begin
              st_q <= D_WAIT;      // Wait for restart or stop
            end
          end
        end
        D_TX: begin
          if (rise) begin
            cnt_q <= cnt_q + BIT_ONE;
          end else if (fall && cnt_q == BIT_ACK) begin
            st_q <= D_TX_ACK;
          end
        end
        D_TX_ACK: begin
          if (rise && sda_s) begin
            st_q <= D_WAIT;        // No ack: stop sending
          end else if (fall) begin
            st_q    <= D_TX;       // Unlimited byte stream
            cnt_q   <= BIT_ZERO;
            shift_q <= rd_data;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Address counter
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      rd_addr_q <= ADDR_RESET;
    end else if (load_addr) begin
      rd_addr_q <= {hi_q, shift_q};
    end else if (fetch) begin
      rd_addr_q <= rd_addr_q + ADDR_ONE;     // Full-width wrap
    end
  end

  // Fetch pulse toward the memory
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      rd_take_q <= 1'b0;
    end else begin
      rd_take_q <= fetch;
    end
  end

  // ==========================================================
  // Data line drive; changes on clock falls, released at start or stop
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      sda_oe_q <= 1'b0;
      sda_o_q  <= 1'b0;
    end else if (start || stop) begin
      sda_oe_q <= 1'b0;
    end else if (fall) begin
      unique case (st_q)
        D_SLA: begin
          sda_oe_q <= (cnt_q == BIT_ACK) && match;
        end
        D_WADR: begin
          sda_oe_q <= (cnt_q == BIT_ACK);           // Ack word address
        end
        D_SLA_ACK: begin
          sda_oe_q <= dir_q & ~rd_data[BYTE_MSB];
        end
        D_TX: begin
          if (cnt_q == BIT_ACK) begin
            sda_oe_q <= 1'b0;                       // Release for master ack
          end else begin
            sda_oe_q <= ~shift_q[BYTE_MSB - cnt_q[2:0]];
          end
        end
        D_TX_ACK: begin
          sda_oe_q <= ~rd_data[BYTE_MSB];
        end
        D_IDLE, D_WADR_ACK, D_WAIT: begin
          sda_oe_q <= 1'b0;                         // Released outside driven slots
        end
      endcase
    end
  end

  assign bus.s_sda_o  = sda_o_q;
  assign bus.s_sda_oe = sda_oe_q;
endmodule

// >>> verilog/sers_host.sv
`timescale 1ns/1ps
module sers_host
  import sers_pkg::*;
(
  input  wire logic              ref_clk,     // System clock
  input  wire logic              resetn,      // Async reset, active low
  sers_bus_if.master             bus,         // Two-wire link
  input  wire logic              cmd_valid,   // Command request
  output logic                   cmd_ready_q, // Idle, command accepted
  input  wire logic [1:0]        cmd_op,      // OP_CUR, OP_RAND, OP_SET
  input  wire logic              cmd_space,   // 1 = control register space
  input  wire logic [ADDR_W-1:0] cmd_addr,    // Word address
  input  wire logic [7:0]        cmd_len,     // Bytes to read minus one
  output logic                   rd_valid_q,  // Pulse: data byte ready
  output logic [7:0]             rd_data_q,   // Received byte
  output logic                   nack_q,      // Pulse: device did not ack
  output logic                   done_q       // Pulse: stop sent
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} sers_hstate_e;
  typedef enum logic [1:0] {S_SLA_W, S_AHI, S_ALO, S_SLA_R} sers_stage_e;

  sers_hstate_e     st_q;
  sers_stage_e      stage_q;
  logic [7:0]       div_q;
  logic [1:0]       ph_q;
  logic [3:0]       bit_q;
  logic [1:0]       op_q;
  logic             space_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]       left_q;
  logic [7:0]       rxb_q;
  logic             ack_q;
  logic             scl_q;
  logic             sda_oe_q;
  logic             sda_s;
  logic             tick;
  logic [6:0]       sla;
  logic [7:0]       txb;

  // ==========================================================
  // Data line synchroniser and quarter-bit divider
  sers_sync #(.W(1)) u_sync (
    .clk   (ref_clk),
    .rst_n (resetn),
    .d     (bus.sda),
    .q     (sda_s)
  );

  assign tick = (div_q == QTR_LAST);

  // Quarter-bit counter
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= DIV_ZERO;
    end else if (tick || st_q == H_IDLE) begin
      div_q <= DIV_ZERO;
    end else begin
      div_q <= div_q + DIV_ONE;
    end
  end

  // Byte to send; same pattern in both phases
  assign sla = space_q ? SLA_CCR : SLA_ARRAY;
  always_comb begin
    unique case (stage_q)
      S_SLA_W: txb = {sla, 1'b0};
      S_AHI:   txb = addr_q[15:8];
      S_ALO:   txb = addr_q[7:0];
      S_SLA_R: txb = {sla, 1'b1};
    endcase
  end

  // ==========================================================
  // Bit and byte sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q        <= H_IDLE;
      stage_q     <= S_SLA_W;
      ph_q        <= 2'h0;
      bit_q       <= BIT_ZERO;
      op_q        <= OP_CUR;
      space_q     <= 1'b0;
      addr_q      <= ADDR_RESET;
      left_q      <= LEN_ZERO;
      rxb_q       <= 8'h00;
      ack_q       <= 1'b0;
      scl_q       <= 1'b1;
      sda_oe_q    <= 1'b0;
      cmd_ready_q <= 1'b0;
      rd_valid_q  <= 1'b0;
      rd_data_q   <= 8'h00;
      nack_q      <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      nack_q     <= 1'b0;
      done_q     <= 1'b0;
      if (st_q == H_IDLE) begin
        cmd_ready_q <= 1'b1;
        if (cmd_valid && cmd_ready_q) begin
          cmd_ready_q <= 1'b0;
          op_q    <= cmd_op;
          space_q <= cmd_space;
          addr_q  <= cmd_addr;
          left_q  <= cmd_len;
          stage_q <= (cmd_op == OP_RAND || cmd_op == OP_SET) ? S_SLA_W : S_SLA_R;
          st_q    <= H_START;
          ph_q    <= 2'h0;
        end
      end else if (tick) begin
        ph_q <= ph_q + PH_ONE;
        unique case (ph_q)
          2'h0: begin
            if (st_q == H_START) sda_oe_q <= 1'b0;
            else if (st_q == H_STOP) sda_oe_q <= 1'b1;
            else if (st_q == H_TX) sda_oe_q <= (bit_q != BIT_ACK) && !txb[BYTE_MSB - bit_q[2:0]];
            else sda_oe_q <= (bit_q == BIT_ACK) && (left_q != LEN_ZERO); // Nack on last
          end
          2'h1: scl_q <= 1'b1;
          2'h2: begin
            if (st_q == H_START) sda_oe_q <= 1'b1;      // Start condition
            else if (st_q == H_STOP) sda_oe_q <= 1'b0;  // Stop condition
            else if (st_q == H_TX) ack_q <= ~sda_s;
            else if (bit_q != BIT_ACK) rxb_q <= {rxb_q[6:0], sda_s};
          end
          2'h3: begin
            if (st_q != H_STOP) scl_q <= 1'b0;
            bit_q <= bit_q + BIT_ONE;
            if (st_q == H_START) begin
              st_q  <= H_TX;
              bit_q <= BIT_ZERO;
            end else if (st_q == H_STOP) begin
              st_q   <= H_IDLE;
              done_q <= 1'b1;
            end else if (bit_q == BIT_ACK && st_q == H_TX) begin
              bit_q <= BIT_ZERO;
              if (!ack_q) begin
                nack_q <= 1'b1;
                st_q   <= H_STOP;
              end else if (stage_q == S_SLA_R) begin
                st_q <= H_RX;
              end else if (stage_q == S_ALO) begin
                st_q <= (op_q == OP_SET) ? H_STOP : H_START;
                stage_q <= S_SLA_R;
              end else begin
                stage_q <= (stage_q == S_SLA_W) ? S_AHI : S_ALO;
              end
            end else if (bit_q == BIT_ACK) begin
              bit_q      <= BIT_ZERO;
              rd_valid_q <= 1'b1;
              rd_data_q  <= rxb_q;
              if (left_q == LEN_ZERO) st_q <= H_STOP;
              else left_q <= left_q - LEN_ONE;
            end
          end
        endcase
      end
    end
  end

  assign bus.scl      = scl_q;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = sda_oe_q;
endmodule

// >>> tb/sers_link_chk.sv
`timescale 1ns/1ps
// ==========
// Link protocol checker
module sers_link_chk
  import sers_pkg::*;
(
  input wire logic ref_clk,  // System clock
  input wire logic link_clk, // Device sampling clock
  input wire logic resetn,   // Async reset, active low
  input wire logic scl,      // Link clock line
  input wire logic m_sda_oe, // Master pulls data low
  input wire logic s_sda_oe, // Device pulls data low
  input wire logic sda       // Resolved data line
);
  logic       scl_q, sda_q, rd_q, nack_q, idle_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  logic       start_w, stop_w, rise_w, ack_w;

  // ==========
  // Frame decoding
  assign start_w = scl & scl_q & sda_q & ~sda;
  assign stop_w  = scl & scl_q & ~sda_q & sda;
  assign rise_w  = scl & ~scl_q;
  assign ack_w   = rise_w & (bit_q == BIT_ACK);

  // Line history
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Bit slot, byte count and shifted bits since start
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bit_q  <= 4'h0;
      byte_q <= 2'h0;
      sh_q   <= 8'h00;
    end else if (start_w) begin
      bit_q  <= 4'h0;
      byte_q <= 2'h0;
    end else if (rise_w) begin
      bit_q <= ack_w ? 4'h0 : bit_q + 4'h1;
      if (!ack_w) sh_q <= {sh_q[6:0], sda};
      if (ack_w && byte_q != 2'h3) byte_q <= byte_q + 2'h1;
    end
  end

  // Direction, master refusal and idle state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_q   <= 1'h0;
      nack_q <= 1'h0;
      idle_q <= 1'h1;
    end else if (start_w || stop_w) begin
      rd_q   <= 1'h0;
      nack_q <= 1'h0;
      idle_q <= stop_w;
    end else if (ack_w) begin
      if (byte_q == 2'h0) rd_q <= sh_q[0];
      if (rd_q && byte_q != 2'h0 && sda) nack_q <= 1'h1;
    end
  end

  // ==========
  // Properties
  a_addr_ack_match: assert property (@(posedge ref_clk) disable iff (!resetn)
    ack_w && byte_q == 2'h0 |-> sda == !(sh_q[7:1] == SLA_ARRAY || sh_q[7:1] == SLA_CCR))
    else $error("address acknowledge wrong");
  a_word_ack: assert property (@(posedge ref_clk) disable iff (!resetn)
    ack_w && !rd_q && (byte_q == 2'h1 || byte_q == 2'h2) |-> !sda)
    else $error("word address not acknowledged");
  a_nack_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    nack_q |-> !s_sda_oe)
    else $error("device drives after master refusal");
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    idle_q |-> !s_sda_oe)
    else $error("device drives while idle");
  a_master_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    rise_w && rd_q && !nack_q && byte_q != 2'h0 && bit_q != BIT_ACK |-> !m_sda_oe)
    else $error("master drives during read data");
  a_ack_slot_free: assert property (@(posedge ref_clk) disable iff (!resetn)
    ack_w && rd_q && byte_q != 2'h0 |-> !s_sda_oe)
    else $error("device drives in master acknowledge slot");
  a_stop_after_nack: assert property (@(posedge ref_clk) disable iff (!resetn)
    ack_w && rd_q && byte_q != 2'h0 && sda |-> ##[1:500] stop_w)
    else $error("no stop after read refusal");
  a_dev_stable_hi: assert property (@(posedge link_clk) disable iff (!resetn)
    scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("device data changes while clock high");

  c_seq_read: cover property (@(posedge ref_clk) ack_w && rd_q && byte_q == 2'h2 && !sda);
  c_restart: cover property (@(posedge ref_clk) start_w && !idle_q);
  c_set_addr: cover property (@(posedge ref_clk) stop_w && !rd_q && byte_q == 2'h3);
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
// ==========
// Host and device joined by the link
module testbench;
  import sers_pkg::*;
  logic        ref_clk, link_clk, resetn, cmd_valid, cmd_ready_q, cmd_space;
  logic        rd_valid_q, nack_q, done_q, rd_space_q, rd_take_q;
  logic [1:0]  cmd_op;
  logic [7:0]  cmd_len, rd_data_q, rd_data;
  logic [15:0] cmd_addr, rd_addr_q, exp_addr;
  logic [31:0] r;
  integer      seed;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          n_take = 0;

  sers_bus_if i_sers_bus_if ();
  sers_host i_sers_host (.ref_clk, .resetn, .bus(i_sers_bus_if), .cmd_valid, .cmd_ready_q,
    .cmd_op, .cmd_space, .cmd_addr, .cmd_len, .rd_valid_q, .rd_data_q, .nack_q, .done_q);
  sers_device i_sers_device (.link_clk, .resetn, .bus(i_sers_bus_if), .rd_addr_q,
    .rd_space_q, .rd_take_q, .rd_data);
  sers_link_chk i_sers_link_chk (.ref_clk, .link_clk, .resetn, .scl(i_sers_bus_if.scl),
    .m_sda_oe(i_sers_bus_if.m_sda_oe), .s_sda_oe(i_sers_bus_if.s_sda_oe),
    .sda(i_sers_bus_if.sda));

  // ==========
  // Memory behind the device and comparisons
  function automatic logic [7:0] mem_byte(input logic sp, input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ (sp ? 8'hC3 : 8'h5A);
  endfunction
  assign rd_data = mem_byte(rd_space_q, rd_addr_q);

  // Count fetch pulses toward the memory, away from their launch edge
  always @(negedge link_clk) begin
    if (rd_take_q === 1'b1) n_take++;
  end

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Issue one command, check each byte, then the counter left behind
  task automatic run_cmd(input logic [1:0] op, input logic sp, input logic [15:0] a,
                         input logic [7:0] len);
    int         n;
    logic [7:0] cnt;
    logic [7:0] nk;
    int         t0;
    t0  = n_take;
    n   = 0;
    cnt = 8'h00;
    nk  = 8'h00;
    if (op != OP_CUR) exp_addr = a;
    while (cmd_ready_q !== 1'b1) @(negedge ref_clk);
    {cmd_op, cmd_space, cmd_addr, cmd_len} = {op, sp, a, len};
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while (done_q !== 1'b1 && n < 25000) begin
      @(negedge ref_clk);
      n++;
      if (rd_valid_q === 1'b1) begin
        check_byte(rd_data_q, mem_byte(sp, exp_addr));
        exp_addr++;
        cnt++;
      end
      if (nack_q === 1'b1) nk++;
    end
    check_byte({7'h00, done_q}, 8'h01);
    check_byte(cnt, op == OP_SET ? 8'h00 : len + 8'h01);
    check_byte(8'(n_take - t0), cnt);
    check_byte(nk, 8'h00);
    check_word(rd_addr_q, exp_addr);
    check_byte({7'h00, rd_space_q}, {7'h00, sp});
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========
  // Clocks, watchdog and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  initial begin
    repeat (98000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    seed = 32'h4553;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    {cmd_op, cmd_space, cmd_addr, cmd_len} = '0;
    exp_addr = 16'h0000;
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    run_cmd(OP_CUR, 1'b0, 16'h9999, 8'h01);
    run_cmd(OP_RAND, 1'b0, 16'hFFFF, 8'h01);
    run_cmd(OP_SET, 1'b0, 16'h007F, 8'h00);
    run_cmd(OP_CUR, 1'b0, 16'h1234, 8'h02);
    run_cmd(OP_RAND, 1'b1, 16'h3C05, 8'h00);
    for (int i = 0; i < 2; i++) begin
      r = $random(seed);
      run_cmd(r[1:0] == 2'h2 ? OP_SET : (r[0] ? OP_RAND : OP_CUR), r[2], r[31:16], 8'h00);
    end
    end_sim();
  end
endmodule
